// file: rtl/nrf_pkg.sv
// Constants and types of the navigation record framer
package nrf_pkg;

    // ==================================================================
    // Framing bytes and record identifiers
    localparam logic [7:0] DLE_BYTE      = 8'h10;
    localparam logic [7:0] ETX_BYTE      = 8'h03;
    localparam logic [7:0] ID_SAT        = 8'h72;
    localparam logic [7:0] ID_POS        = 8'h33;
    localparam logic [7:0] SAT_LEN       = 8'h54;
    localparam logic [7:0] POS_LEN       = 8'h40;
    localparam logic [7:0] SAT_COUNT     = 8'h0C;
    localparam logic [2:0] SAT_ENTRY     = 3'h7;
    localparam logic [2:0] SAT_STAT_POS  = 3'h6;
    localparam logic [7:0] SVID_MAX      = 8'h40;
    localparam logic [7:0] STATUS_MASK   = 8'h07;
    localparam logic [7:0] POS_FIX_OFS   = 8'h10;
    localparam logic [7:0] FIX_MAX       = 8'h05;

    // ==================================================================
    // USB header
    localparam logic [7:0] USB_TRANSPORT = 8'h14;
    localparam logic [7:0] USB_HDR_LAST  = 8'h0B;
    localparam logic [7:0] USB_ID_POS    = 8'h04;
    localparam logic [7:0] USB_LEN_POS   = 8'h08;

    // ==================================================================
    // Rate change handshake
    localparam logic [7:0] ID_RQST       = 8'h1C;
    localparam logic [7:0] ID_ACK        = 8'h06;
    localparam logic [7:0] ID_RATE_REQ   = 8'h30;
    localparam logic [7:0] ID_RATE_ACC   = 8'h31;
    localparam logic [7:0] ID_CMD        = 8'h0A;
    localparam logic [7:0] PING_CODE     = 8'h3A;
    localparam logic [31:0] RATE_FALLBACK = 32'h0000_2580;
    localparam logic [5:0][31:0] RATE_TAB = {32'h0001_C200, 32'h0000_E100, 32'h0000_9600,
                                             32'h0000_4B00, 32'h0000_2580, 32'h0000_12C0};

    // ==================================================================
    // Timing
    localparam longint CLK_HZ        = 100000000;
    localparam longint TRIAL_MS      = 2000;
    localparam longint TRIAL_CYCLES  = TRIAL_MS * (CLK_HZ / 1000);

    // ==================================================================
    // State types
    typedef enum logic [3:0] {
        TX_IDLE = 4'h0, TX_LEAD = 4'h1, TX_ID = 4'h2, TX_LEN = 4'h3, TX_DATA = 4'h4,
        TX_SUM = 4'h5, TX_TDLE = 4'h6, TX_ETX = 4'h7, TX_USB = 4'h8
    } nrf_tx_t;
    typedef enum logic [1:0] {RX_HUNT = 2'h0, RX_DAT = 2'h1, RX_ESC = 2'h2} nrf_rx_t;
    typedef enum logic [1:0] {B_IDLE = 2'h0, B_ARMED = 2'h1, B_OFFER = 2'h2, B_TRIAL = 2'h3}
        nrf_baud_t;

endpackage : nrf_pkg

// file: rtl/nrf_framer.sv
// Payload FIFO and record framer, deframer and rate change handshake
`timescale 1ns/1ps

// ======================================================================
// Payload FIFO
module nrf_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;

    if (D < 2 || (1 << AW) != D) $error("FIFO depth must be a power of two");

    assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
            if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
        end
    end
endmodule : nrf_fifo

// ======================================================================
// Framer top
// Notes on behaviour
// - Satellite record uses identifier 0x72 and 84 payload bytes for 12 satellites.
// - Each satellite entry is 7 bytes: id, snr, elevation, azimuth, status.
// - Satellite id is 1-32 for ranging, 33-64 for augmentation satellites.
// - Status bit 0 ephemeris, bit 1 correction, bit 2 used in solution.
// - Serial record starts with 0x10, identifier byte, then payload length byte.
// - Checksum is two's complement of the byte sum between the delimiters.
// - Serial record ends with 0x10 then 0x03 as the final byte.
// - Any 0x10 inside the serial frame is sent twice; USB mode sends it once.
// - USB header starts with transport 0x14 padded, then identifier padded.
// - USB header then holds length (0x54 satellite, 0x40 position) and payload, without checksum or delimiters.
// - Position record fields in fixed order, altitude first, day count last.
// - Fix codes: 0,1 none, 2 2D, 3 3D, 4 and 5 differential.
// - Position record uses identifier 0x33.
// - Request-data packet 0x1C with zero is answered by acknowledge 0x06.
// - Device answers with accept 0x31 holding the highest table rate not above the request, else 4800.
// - Two pings 0x0A/0x3A are each answered by acknowledge 0x06 carrying 0x0A.
// - Without both pings within two seconds the rate returns to 9600.
module nrf_framer #(
    parameter int          FIFO_DEPTH   = 4,
    parameter longint      TRIAL_CYCLES = nrf_pkg::TRIAL_CYCLES,
    parameter logic [31:0] RESET_RATE   = nrf_pkg::RATE_FALLBACK
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        usb_mode,
    input  wire logic        rec_start,
    input  wire logic        rec_kind,
    output logic             rec_ready,
    input  wire logic [7:0]  pay_data,
    input  wire logic        pay_valid,
    output logic             pay_ready,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic [31:0]      link_rate,
    output logic             rate_trial,
    output logic             frame_err,
    output logic             field_err
);
    localparam int TW = $clog2(TRIAL_CYCLES + 1);

    if (TRIAL_CYCLES < 1) $error("TRIAL_CYCLES must be at least one");

    function automatic logic [31:0] pick_rate(input logic [31:0] req);
        logic [31:0] best;
        best = nrf_pkg::RATE_TAB[0];
        for (int i = 0; i < 6; i++) begin
            if (nrf_pkg::RATE_TAB[i] <= req) best = nrf_pkg::RATE_TAB[i];
        end
        return best;
    endfunction : pick_rate

    function automatic logic is_escaped(input nrf_pkg::nrf_tx_t st);
        return st == nrf_pkg::TX_ID || st == nrf_pkg::TX_LEN || st == nrf_pkg::TX_DATA
            || st == nrf_pkg::TX_SUM;
    endfunction : is_escaped

    // ==================================================================
    // Payload buffer
    logic [7:0] fifo_d;
    logic       fifo_v;
    logic       fifo_pop;

    nrf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_data   (pay_data),
        .in_valid  (pay_valid),
        .in_ready  (pay_ready),
        .out_data  (fifo_d),
        .out_valid (fifo_v),
        .out_ready (fifo_pop)
    );

    // ==================================================================
    // Transmit state
    nrf_pkg::nrf_tx_t tx_st_q;
    logic [7:0]       id_q;
    logic [7:0]       len_q;
    logic [7:0]       idx_q;
    logic [7:0]       sum_q;
    logic [2:0]       ent_q;
    logic             dup_q;
    logic             usb_q;
    logic             src_rep_q;
    logic             rec_pend_q;
    logic             rec_kind_q;
    logic             rep_pend_q;
    logic [7:0]       rep_id_q;
    logic [7:0]       rep_len_q;
    logic [7:0]       rep_buf_q [4];
    logic [7:0]       cur_byte;
    logic [7:0]       data_byte;
    logic             fire;
    logic             esc_need;
    logic             advance;
    logic             take_rep;

    // Status byte keeps only its three defined flags
    always_comb begin
        if (src_rep_q) begin
            data_byte = rep_buf_q[idx_q[1:0]];
        end else if (id_q == nrf_pkg::ID_SAT && ent_q == nrf_pkg::SAT_STAT_POS) begin
            data_byte = fifo_d & nrf_pkg::STATUS_MASK;
        end else begin
            data_byte = fifo_d;
        end
    end

    always_comb begin
        unique case (tx_st_q)
            nrf_pkg::TX_IDLE: cur_byte = 8'h00;
            nrf_pkg::TX_LEAD: cur_byte = nrf_pkg::DLE_BYTE;
            nrf_pkg::TX_ID:   cur_byte = id_q;
            nrf_pkg::TX_LEN:  cur_byte = len_q;
            nrf_pkg::TX_DATA: cur_byte = data_byte;
            nrf_pkg::TX_SUM:  cur_byte = 8'(~sum_q + 8'h01);
            nrf_pkg::TX_TDLE: cur_byte = nrf_pkg::DLE_BYTE;
            nrf_pkg::TX_ETX:  cur_byte = nrf_pkg::ETX_BYTE;
            nrf_pkg::TX_USB: begin
                if (idx_q == 8'h00)                      cur_byte = nrf_pkg::USB_TRANSPORT;
                else if (idx_q == nrf_pkg::USB_ID_POS)   cur_byte = id_q;
                else if (idx_q == nrf_pkg::USB_LEN_POS)  cur_byte = len_q;
                else                                     cur_byte = 8'h00;
            end
            default: cur_byte = 8'h00;
        endcase
    end

    assign tx_data   = cur_byte;
    assign tx_valid  = (tx_st_q != nrf_pkg::TX_IDLE)
                     && !(tx_st_q == nrf_pkg::TX_DATA && !src_rep_q && !fifo_v);
    assign fire      = tx_valid && tx_ready;
    assign esc_need  = is_escaped(tx_st_q) && !usb_q && !dup_q
                     && cur_byte == nrf_pkg::DLE_BYTE;
    assign advance   = fire && !esc_need;
    assign fifo_pop  = advance && tx_st_q == nrf_pkg::TX_DATA && !src_rep_q;
    assign take_rep  = tx_st_q == nrf_pkg::TX_IDLE && rep_pend_q;
    assign rec_ready = !rec_pend_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_st_q   <= nrf_pkg::TX_IDLE;
            id_q      <= 8'h00;
            len_q     <= 8'h00;
            idx_q     <= 8'h00;
            sum_q     <= 8'h00;
            ent_q     <= 3'h0;
            dup_q     <= 1'b0;
            usb_q     <= 1'b0;
            src_rep_q <= 1'b0;
        end else if (tx_st_q == nrf_pkg::TX_IDLE) begin
            idx_q <= 8'h00;
            sum_q <= 8'h00;
            ent_q <= 3'h0;
            dup_q <= 1'b0;
            if (rep_pend_q) begin
                src_rep_q <= 1'b1;
                usb_q     <= 1'b0;
                id_q      <= rep_id_q;
                len_q     <= rep_len_q;
                tx_st_q   <= nrf_pkg::TX_LEAD;
            end else if (rec_pend_q) begin
                src_rep_q <= 1'b0;
                usb_q     <= usb_mode;
                id_q      <= rec_kind_q ? nrf_pkg::ID_POS : nrf_pkg::ID_SAT;
                len_q     <= rec_kind_q ? nrf_pkg::POS_LEN : nrf_pkg::SAT_LEN;
                tx_st_q   <= usb_mode ? nrf_pkg::TX_USB : nrf_pkg::TX_LEAD;
            end
        end else if (fire && esc_need) begin
            dup_q <= 1'b1;
        end else if (advance) begin
            dup_q <= 1'b0;
            unique case (tx_st_q)
                nrf_pkg::TX_LEAD: tx_st_q <= nrf_pkg::TX_ID;
                nrf_pkg::TX_ID: begin
                    sum_q   <= sum_q + cur_byte;
                    tx_st_q <= nrf_pkg::TX_LEN;
                end
                nrf_pkg::TX_LEN: begin
                    sum_q   <= sum_q + cur_byte;
                    idx_q   <= 8'h00;
                    tx_st_q <= (len_q == 8'h00) ? nrf_pkg::TX_SUM : nrf_pkg::TX_DATA;
                end
                nrf_pkg::TX_USB: begin
                    idx_q   <= (idx_q == nrf_pkg::USB_HDR_LAST) ? 8'h00 : idx_q + 8'h01;
                    if (idx_q == nrf_pkg::USB_HDR_LAST) tx_st_q <= nrf_pkg::TX_DATA;
                end
                nrf_pkg::TX_DATA: begin
                    sum_q <= sum_q + cur_byte;
                    idx_q <= idx_q + 8'h01;
                    ent_q <= (ent_q == nrf_pkg::SAT_ENTRY - 3'h1) ? 3'h0 : ent_q + 3'h1;
                    if (idx_q == len_q - 8'h01) begin
                        tx_st_q <= usb_q ? nrf_pkg::TX_IDLE : nrf_pkg::TX_SUM;
                    end
                end
                nrf_pkg::TX_SUM:  tx_st_q <= nrf_pkg::TX_TDLE;
                nrf_pkg::TX_TDLE: tx_st_q <= nrf_pkg::TX_ETX;
                nrf_pkg::TX_ETX:  tx_st_q <= nrf_pkg::TX_IDLE;
                default:          tx_st_q <= nrf_pkg::TX_IDLE;
            endcase
        end
    end

    // Record request latch; a start while one waits is dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rec_pend_q <= 1'b0;
            rec_kind_q <= 1'b0;
        end else if (rec_start && !rec_pend_q) begin
            rec_pend_q <= 1'b1;
            rec_kind_q <= rec_kind;
        end else if (tx_st_q == nrf_pkg::TX_IDLE && !rep_pend_q && rec_pend_q) begin
            rec_pend_q <= 1'b0;
        end
    end

    // Payload field checks, flagged but still sent
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            field_err <= 1'b0;
        end else begin
            field_err <= fifo_pop && (
                (id_q == nrf_pkg::ID_SAT && ent_q == 3'h0
                    && (fifo_d == 8'h00 || fifo_d > nrf_pkg::SVID_MAX))
                || (id_q == nrf_pkg::ID_POS && idx_q == nrf_pkg::POS_FIX_OFS
                    && fifo_d > nrf_pkg::FIX_MAX));
        end
    end

    // ==================================================================
    // Receive deframer
    nrf_pkg::nrf_rx_t rx_st_q;
    logic [7:0]       rx_cnt_q;
    logic [7:0]       rx_sum_q;
    logic [7:0]       rx_buf_q [8];
    logic             rx_store;
    logic             frame_end;
    logic             frame_ok;

    assign rx_store  = rx_valid && ((rx_st_q == nrf_pkg::RX_DAT && rx_data != nrf_pkg::DLE_BYTE)
                     || (rx_st_q == nrf_pkg::RX_ESC && rx_data != nrf_pkg::ETX_BYTE));
    assign frame_end = rx_valid && rx_st_q == nrf_pkg::RX_ESC && rx_data == nrf_pkg::ETX_BYTE;
    assign frame_ok  = frame_end && rx_sum_q == 8'h00 && rx_cnt_q >= 8'h03
                     && rx_buf_q[1] == rx_cnt_q - 8'h03;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_st_q  <= nrf_pkg::RX_HUNT;
            rx_cnt_q <= 8'h00;
            rx_sum_q <= 8'h00;
        end else if (rx_valid) begin
            unique case (rx_st_q)
                nrf_pkg::RX_HUNT: begin
                    rx_cnt_q <= 8'h00;
                    rx_sum_q <= 8'h00;
                    if (rx_data == nrf_pkg::DLE_BYTE) rx_st_q <= nrf_pkg::RX_ESC;
                end
                nrf_pkg::RX_DAT: begin
                    if (rx_data == nrf_pkg::DLE_BYTE) rx_st_q <= nrf_pkg::RX_ESC;
                end
                nrf_pkg::RX_ESC: begin
                    rx_st_q <= (rx_data == nrf_pkg::ETX_BYTE) ? nrf_pkg::RX_HUNT
                                                              : nrf_pkg::RX_DAT;
                end
                default: rx_st_q <= nrf_pkg::RX_HUNT;
            endcase
            if (rx_store) begin
                rx_cnt_q <= rx_cnt_q + 8'h01;
                rx_sum_q <= rx_sum_q + rx_data;
            end
        end
    end

    // Only the short command frames matter, so the head is kept
    always_ff @(posedge clk_sys) begin
        if (rx_store && rx_cnt_q < 8'h08) begin
            rx_buf_q[rx_cnt_q[2:0]] <= rx_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) frame_err <= 1'b0;
        else       frame_err <= frame_end && !frame_ok;
    end

    // ==================================================================
    // Rate change handshake
    nrf_pkg::nrf_baud_t b_st_q;
    logic [31:0]        rate_q;
    logic [31:0]        offer_q;
    logic [TW-1:0]      timer_q;
    logic               ping_q;
    logic               rep_set;
    logic [7:0]         rep_id_d;
    logic [7:0]         rep_len_d;
    logic [31:0]        rep_word_d;
    logic [31:0]        req_rate;
    logic               is_rqst;
    logic               is_rreq;
    logic               is_aack;
    logic               is_ping;

    assign req_rate = {rx_buf_q[5], rx_buf_q[4], rx_buf_q[3], rx_buf_q[2]};
    assign is_rqst  = frame_ok && rx_buf_q[0] == nrf_pkg::ID_RQST && rx_buf_q[1] == 8'h02
                    && rx_buf_q[2] == 8'h00 && rx_buf_q[3] == 8'h00;
    assign is_rreq  = frame_ok && rx_buf_q[0] == nrf_pkg::ID_RATE_REQ && rx_buf_q[1] == 8'h04;
    assign is_aack  = frame_ok && rx_buf_q[0] == nrf_pkg::ID_ACK && rx_buf_q[1] != 8'h00
                    && rx_buf_q[2] == nrf_pkg::ID_RATE_ACC;
    assign is_ping  = frame_ok && rx_buf_q[0] == nrf_pkg::ID_CMD && rx_buf_q[1] != 8'h00
                    && rx_buf_q[2] == nrf_pkg::PING_CODE;

    always_comb begin
        rep_set    = 1'b0;
        rep_id_d   = nrf_pkg::ID_ACK;
        rep_len_d  = 8'h02;
        rep_word_d = 32'h0000_0000;
        if (is_rqst) begin
            rep_set    = 1'b1;
            rep_word_d = {24'h00_0000, nrf_pkg::ID_RQST};
        end else if (is_rreq && b_st_q == nrf_pkg::B_ARMED) begin
            rep_set    = 1'b1;
            rep_id_d   = nrf_pkg::ID_RATE_ACC;
            rep_len_d  = 8'h04;
            rep_word_d = pick_rate(req_rate);
        end else if (is_ping) begin
            rep_set    = 1'b1;
            rep_word_d = {24'h00_0000, nrf_pkg::ID_CMD};
        end
    end

    // A new answer wins over the hand-off of the previous one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rep_pend_q <= 1'b0;
            rep_id_q   <= 8'h00;
            rep_len_q  <= 8'h00;
        end else if (rep_set && !(rep_pend_q && !take_rep)) begin
            rep_pend_q <= 1'b1;
            rep_id_q   <= rep_id_d;
            rep_len_q  <= rep_len_d;
            for (int i = 0; i < 4; i++) begin
                rep_buf_q[i] <= rep_word_d[8*i +: 8];
            end
        end else if (take_rep) begin
            rep_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            b_st_q  <= nrf_pkg::B_IDLE;
            rate_q  <= RESET_RATE;
            offer_q <= RESET_RATE;
            timer_q <= '0;
            ping_q  <= 1'b0;
        end else begin
            unique case (b_st_q)
                nrf_pkg::B_IDLE, nrf_pkg::B_ARMED: begin
                    if (is_rqst) begin
                        b_st_q <= nrf_pkg::B_ARMED;
                    end else if (is_rreq && b_st_q == nrf_pkg::B_ARMED) begin
                        offer_q <= pick_rate(req_rate);
                        b_st_q  <= nrf_pkg::B_OFFER;
                    end
                end
                nrf_pkg::B_OFFER: begin
                    if (is_aack) begin
                        rate_q  <= offer_q;
                        timer_q <= '0;
                        ping_q  <= 1'b0;
                        b_st_q  <= nrf_pkg::B_TRIAL;
                    end else if (is_rqst) begin
                        b_st_q <= nrf_pkg::B_ARMED;
                    end else if (frame_ok) begin
                        b_st_q <= nrf_pkg::B_IDLE;
                    end
                end
                nrf_pkg::B_TRIAL: begin
                    timer_q <= timer_q + 1'b1;
                    if (is_ping && ping_q) begin
                        b_st_q <= nrf_pkg::B_IDLE;
                    end else if (timer_q == TW'(TRIAL_CYCLES - 1)) begin
                        rate_q <= nrf_pkg::RATE_FALLBACK;
                        b_st_q <= nrf_pkg::B_IDLE;
                    end else if (is_ping) begin
                        ping_q <= 1'b1;
                    end
                end
                default: b_st_q <= nrf_pkg::B_IDLE;
            endcase
        end
    end

    assign link_rate  = rate_q;
    assign rate_trial = (b_st_q == nrf_pkg::B_TRIAL);

endmodule : nrf_framer

// file: dv/nrf_framer_sva.sv
// Port checker for the record framer
`timescale 1ns/1ps

// ======================================================================
// Checker
module nrf_framer_sva #(
    parameter longint TRIAL_CYCLES = 200
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        rec_start,
    input wire logic        rec_ready,
    input wire logic        pay_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [31:0] link_rate,
    input wire logic        rate_trial,
    input wire logic        frame_err,
    input wire logic        field_err
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Counter, since the trial span is far beyond a repetition count
    longint trial_q;
    always_ff @(posedge clk_sys) trial_q <= (reset || !rate_trial) ? 0 : trial_q + 1;

    a_reset_out_idle: assert property ($past(reset) |-> !tx_valid && rec_ready && pay_ready)
        else $error("outputs not idle after reset");
    a_reset_rate_base: assert property ($past(reset) |-> link_rate == 32'h0000_2580
        && !rate_trial && !frame_err && !field_err) else $error("rate not base after reset");
    a_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before taken");
    a_rec_take_busy: assert property (rec_start && rec_ready |=> !rec_ready)
        else $error("record not taken");
    a_trial_span_bound: assert property (trial_q <= TRIAL_CYCLES + 2)
        else $error("trial outlived its span");
    a_trial_rate_stable: assert property (rate_trial && $past(rate_trial) |-> $stable(link_rate))
        else $error("rate moved during trial");
    a_rate_in_table: assert property (link_rate inside {32'h0000_12C0, 32'h0000_2580,
        32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200}) else $error("odd rate");
    a_frame_err_pulse: assert property (frame_err |=> !frame_err)
        else $error("frame error not a pulse");
    a_field_err_pulse: assert property (field_err |=> !field_err)
        else $error("field error not a pulse");
endmodule : nrf_framer_sva

bind nrf_framer nrf_framer_sva #(.TRIAL_CYCLES(TRIAL_CYCLES)) u_sva (.*);

// file: dv/nrf_host_model.sv
// Host model: byte sink with stalls and raw frame sender
`timescale 1ns/1ps

// ======================================================================
// Host
module nrf_host_model (
    input wire logic  clk_sys,
    input wire logic  [7:0] tx_data,
    input wire logic  tx_valid,
    output logic      tx_ready,
    output logic [7:0] rx_data,
    output logic      rx_valid
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    logic [1:0] ph = 2'h0;
    initial begin
        tx_ready = 1'b1;
        rx_data = 8'hA5;
        rx_valid = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end
    always @(negedge clk_sys) begin
        ph <= ph + 2'h1;
        tx_ready <= !slow || ph == 2'h3;
    end
    // Bytes arrive already framed and escaped, one per cycle
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(negedge clk_sys);
            rx_data = q[i];
            rx_valid = 1'b1;
        end
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask : send
endmodule : nrf_host_model

// file: dv/test_nrf_framer.sv
// Self-checking bench for the record framer
`timescale 1ns/1ps

// ======================================================================
// Bench
module test_nrf_framer;
    typedef logic [7:0] nrf_q_t[$];
    localparam logic [7:0] zb = 8'h00;
    logic clk_sys = 1'b0;
    logic reset, usb_mode, rec_start, rec_kind, pay_valid, rx_valid, tx_ready;
    logic rec_ready, pay_ready, tx_valid, rate_trial, frame_err, field_err;
    logic [7:0] pay_data, tx_data, rx_data;
    logic [31:0] link_rate;
    int fail_count = 0, cmp_count = 0, ferr = 0, serr = 0;
    nrf_framer #(.TRIAL_CYCLES(200)) dut (.*);
    nrf_host_model host (.*);
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        ferr += frame_err;
        serr += field_err;
    end

    // ==================================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    function automatic nrf_q_t ser(input logic [7:0] id, input nrf_q_t d);
        nrf_q_t b, r;
        logic [7:0] s;
        b = {id, 8'(d.size()), d};
        s = zb;
        foreach (b[i]) s -= b[i];
        b.push_back(s);
        r = {8'h10};
        foreach (b[i]) begin
            r.push_back(b[i]);
            if (b[i] == 8'h10) r.push_back(8'h10);
        end
        return {r, 8'h10, 8'h03};
    endfunction : ser
    task automatic expect_tx(input nrf_q_t e);
        int n;
        n = 0;
        while (host.got.size() < e.size() && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
        foreach (e[i]) check("tx byte", host.got[i], e[i]);
        host.got.delete();
    endtask : expect_tx
    task automatic feed(input nrf_q_t d);
        foreach (d[i]) begin
            @(negedge clk_sys);
            pay_data = d[i];
            pay_valid = 1'b1;
            do @(posedge clk_sys); while (pay_ready !== 1'b1);
        end
        @(negedge clk_sys);
        pay_valid = 1'b0;
    endtask : feed
    task automatic record(input logic kind, usb, input nrf_q_t d);
        feed(d[0:3]);
        check("pay_ready", pay_ready, 1'b0);
        rec_kind = kind;
        usb_mode = usb;
        rec_start = 1'b1;
        @(negedge clk_sys);
        rec_start = 1'b0;
        check("rec_ready", rec_ready, 1'b0);
        feed(d[4:$]);
    endtask : record
    task automatic cmd(input logic [7:0] id, rid, input nrf_q_t d, r);
        host.send(ser(id, d));
        expect_tx(ser(rid, r));
    endtask : cmd
    task automatic accept(input nrf_q_t rq, ac, input logic [31:0] rate);
        cmd(8'h1C, 8'h06, {zb, zb}, {8'h1C, zb});
        cmd(8'h30, 8'h31, rq, ac);
        host.send(ser(8'h06, {8'h31, zb}));
        repeat (20) @(negedge clk_sys);
        check("rate", link_rate, rate);
    endtask : accept

    // ==================================================================
    // Sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end
    initial begin
        nrf_q_t d, e;
        {reset, usb_mode, rec_start, rec_kind, pay_valid, pay_data} = {5'h10, 8'h00};
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        for (int u = 0; u < 2; u++) begin
            d = {};
            e = {};
            for (int i = 0; i < 12; i++) begin
                d = {d, 8'(i * 6), 8'h10, 8'(i), 8'h2D, 8'h01, 8'h3C, 8'hF8 | 8'(i)};
                e = {e, d[i * 7:i * 7 + 5], 8'(i) & 8'h07};
            end
            host.slow = (u == 0);
            record(1'b0, u == 1, d);
            if (u == 0) expect_tx(ser(8'h72, e));
            else expect_tx({8'h14, zb, zb, zb, 8'h72, zb, zb, zb, 8'h54, zb, zb, zb, e});
        end
        host.slow = 1'b0;
        d = {};
        for (int i = 0; i < 64; i++) d.push_back(8'(i));
        d[16] = 8'h06;
        record(1'b1, 1'b0, d);
        expect_tx(ser(8'h33, d));
        accept({zb, 8'h96, zb, zb}, {zb, 8'h96, zb, zb}, 32'h0000_9600);
        check("trial", rate_trial, 1'b1);
        repeat (2) cmd(8'h0A, 8'h06, {8'h3A, zb}, {8'h0A, zb});
        check("trial end", rate_trial, 1'b0);
        cmd(8'h1C, 8'h06, {zb, zb}, {8'h1C, zb});
        cmd(8'h30, 8'h31, {8'h20, 8'h4E, zb, zb}, {zb, 8'h4B, zb, zb});
        cmd(8'h0A, 8'h06, {8'h3A, zb}, {8'h0A, zb});
        check("rate kept", link_rate, 32'h0000_9600);
        accept({8'h20, 8'h4E, zb, zb}, {zb, 8'h4B, zb, zb}, 32'h0000_4B00);
        repeat (230) @(negedge clk_sys);
        check("fallback", link_rate, 32'h0000_2580);
        e = ser(8'h0A, {8'h3A, zb});
        e[5] ^= 8'h01;
        host.send(e);
        repeat (20) @(negedge clk_sys);
        check("frame_err", ferr, 1);
        check("no reply", host.got.size(), 0);
        check("field_err", serr, 5);
        end_sim();
    end
endmodule : test_nrf_framer
